// ### core/pbarb_pkg.sv
package pbarb_pkg;

   // Register byte offsets on the APB port
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DATA_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_RSAR = 8'h08;
   localparam logic [7:0] ADDR_RBCR = 8'h0C;
   localparam logic [7:0] ADDR_RDMA_CMD = 8'h10;
   localparam logic [7:0] ADDR_DATA_PORT = 8'h14;
   localparam logic [7:0] ADDR_RESET_PORT = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_LDMA_ADDR = 8'h20;

   // Control register bits
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int CTRL_REGRST_BIT = 2;
   localparam int CTRL_SHARED_BIT = 3;

   // Remote DMA command bits
   localparam int CMD_RREAD_BIT = 0;
   localparam int CMD_RWRITE_BIT = 1;
   localparam int CMD_ABORT_BIT = 2;

   // Status register fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_RBUSY_BIT = 3;
   localparam int STAT_LATCH_BIT = 4;
   localparam int STAT_SHARED_BIT = 5;
   localparam int STAT_ERR_LSB = 8;

   // Values after reset
   localparam logic [1:0] DCFG_BURST_RST = 2'h0;
   localparam logic [15:0] RSAR_RST = 16'h0000;
   localparam logic [15:0] RBCR_RST = 16'h0000;
   localparam logic [15:0] LDMA_ADDR_RST = 16'h0000;
   localparam logic SHARED_RST = 1'b0;
   // Synchroniser reset: bit 0 hard reset pin (inactive high), bit 1 host request
   localparam logic [1:0] SYNC_RST = 2'h1;

   // Burst of (select + 1) * BURST_UNIT bytes
   localparam logic [3:0] BURST_UNIT = 4'h2;

   // Bus states, Gray coded along reset, idle, local, remote
   typedef enum logic [2:0] {
      ST_RESET = 3'h0,
      ST_IDLE = 3'h1,
      ST_LOCAL = 3'h3,
      ST_REMOTE = 3'h2,
      ST_GAP = 3'h6,
      ST_HOST = 3'h7
   } pbarb_state_t;

endpackage

// ### core/pbarb_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pbarb_sync #(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, active low
   input wire logic [WIDTH-1:0] d_in, // Raw pin levels
   output logic [WIDTH-1:0] q_out // Filtered levels
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic q_reg;
         // Only the second stage looks at the first; a change counts once stages 2 and 3 agree
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_reg <= RESET_VAL[i];
               s2_reg <= RESET_VAL[i];
               s3_reg <= RESET_VAL[i];
               q_reg <= RESET_VAL[i];
            end else begin
               s1_reg <= d_in[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  q_reg <= s3_reg;
               end
            end
         end
         assign q_out[i] = q_reg;
      end
   endgenerate

endmodule

`default_nettype wire

// ### core/pbarb_arbiter.sv
// Overview of operation
// (RQ1) Host side is an APB slave only; it never starts a cycle of its own.
// (RQ2) Memory bus is always master, host-owned slave, or idle; never anything else.
// (RQ3) After hardware reset the block sits in the reset state as bus slave.
// (RQ4) Receiver and transmitter are held disabled throughout the reset state.
// (RQ5) Stop, register reset, hard reset pin or FIFO/ring errors force reset state.
// (RQ6) Register reset: reset port in I/O mode, control bit in shared mode.
// (RQ7) Software configures first; the start command moves reset to idle.
// (RQ8) Idle never drives the memory bus until a DMA transfer is needed.
// (RQ9) FIFO request leaves idle and drives the bus for read or write cycles.
// (RQ10) In I/O mode a programmed remote DMA is a second bus requester.
// (RQ11) In shared mode the host gets the memory bus directly, no DMA.
// (RQ12) Each local burst moves the configured byte count, then releases; after a reset cuts one short, the next burst only finishes it.
// (RQ13) Next local burst waits until the FIFO threshold is crossed again.
// (RQ14) In I/O mode host data moves only through the data port by remote DMA.
// (RQ15) Local DMA during packet traffic preempts pending or running remote DMA.
// (RQ16) After local DMA ends, remote DMA re-arbitrates and resumes where it stopped.
// (RQ17) FIFO service needed during a remote cycle is appended right after it.
// (RQ18) Passing from local to remote ownership inserts an idle gap cycle.
// (RQ19) Remote DMA arbitrates per transfer; local DMA uses bursts.
// (RQ20) Remote DMA releases RAM after each byte; held off during local DMA.
// (RQ21) One grant at a time; simultaneous local and remote requests go local.
// (RQ22) Memory outputs undriven in reset, idle, gap and host-owned states.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pbarb_arbiter (
   input wire logic pclk, // Clock, 250 MHz
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic hard_reset_pin_n, // Hard reset pin, active low
   input wire logic host_req_pin, // Shared mode host bus request pin
   output logic host_grant, // Host owns the memory bus
   input wire logic fifo_req, // FIFO above threshold, wants service
   input wire logic fifo_to_mem, // 1 receive (write RAM), 0 transmit (read RAM)
   input wire logic [7:0] fifo_wdata, // Byte from FIFO to RAM
   output logic fifo_take, // FIFO byte consumed this cycle
   output logic [7:0] fifo_rdata, // Byte from RAM to FIFO
   output logic fifo_push, // fifo_rdata valid, one cycle
   input wire logic fifo_underflow, // Error pulse
   input wire logic fifo_overflow, // Error pulse
   input wire logic ring_overflow, // Error pulse
   output logic rx_enable, // Receiver enabled
   output logic tx_enable, // Transmitter enabled
   output logic mem_drive, // Memory bus output enable
   output logic [15:0] mem_addr, // Memory address
   output logic [7:0] mem_wdata, // Memory write data
   input wire logic [7:0] mem_rdata, // Memory read data, valid in strobe cycle
   output logic mem_rd, // Memory read strobe
   output logic mem_wr // Memory write strobe
);

   pbarb_pkg::pbarb_state_t state_reg, state_next;

   logic shared_reg;
   logic [1:0] burst_sel_reg;
   logic [15:0] rsar_reg;
   logic [15:0] rbcr_reg;
   logic [15:0] ldma_addr_reg;
   logic rbusy_reg;
   logic rdir_read_reg;
   logic [7:0] latch_reg;
   logic latch_full_reg;
   logic armed_reg;
   logic [3:0] bcnt_reg;
   logic [2:0] err_reg;
   logic [7:0] fifo_rdata_reg;
   logic fifo_push_reg;
   logic [31:0] prdata_reg;
   logic rd_ok_reg;

   // Pin synchroniser
   logic [1:0] pins_s;
   pbarb_sync #(
      .WIDTH(2),
      .RESET_VAL(pbarb_pkg::SYNC_RST)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d_in({host_req_pin, hard_reset_pin_n}),
      .q_out(pins_s)
   );
   wire hard_rst = ~pins_s[0];
   wire host_req_s = pins_s[1];

   // APB decode
   wire acc = psel & penable;
   wire sel_ctrl = (paddr == pbarb_pkg::ADDR_CTRL);
   wire sel_dcfg = (paddr == pbarb_pkg::ADDR_DATA_CONFIG);
   wire sel_rsar = (paddr == pbarb_pkg::ADDR_RSAR);
   wire sel_rbcr = (paddr == pbarb_pkg::ADDR_RBCR);
   wire sel_cmd = (paddr == pbarb_pkg::ADDR_RDMA_CMD);
   wire sel_port = (paddr == pbarb_pkg::ADDR_DATA_PORT);
   wire sel_rport = (paddr == pbarb_pkg::ADDR_RESET_PORT);
   wire sel_stat = (paddr == pbarb_pkg::ADDR_STATUS);
   wire sel_ldma = (paddr == pbarb_pkg::ADDR_LDMA_ADDR);
   wire addr_hit = sel_ctrl | sel_dcfg | sel_rsar | sel_rbcr | sel_cmd | sel_port |
                   sel_rport | sel_stat | sel_ldma;

   // Data port waits: a read stalls until the latch holds a fetched byte,
   // a write stalls until the previous byte has gone to RAM
   // The last fetched byte leaves busy low, so a full latch keeps the port live
   wire rd_port_live = rdir_read_reg & (rbusy_reg | latch_full_reg);
   wire port_rd_wait = rd_port_live & ~rd_ok_reg;
   wire port_wr_wait = rbusy_reg & ~rdir_read_reg & latch_full_reg;
   wire port_wait = sel_port & (pwrite ? port_wr_wait : port_rd_wait);
   assign pready = ~port_wait; // see (RQ1)
   assign pslverr = acc & ~addr_hit;
   assign prdata = prdata_reg;

   wire wr_acc = acc & pwrite & pready & addr_hit;
   wire rd_acc = acc & ~pwrite & pready & addr_hit;
   wire wr_ctrl = wr_acc & sel_ctrl;
   wire start_cmd = wr_ctrl & pwdata[pbarb_pkg::CTRL_START_BIT];
   wire stop_cmd = wr_ctrl & pwdata[pbarb_pkg::CTRL_STOP_BIT];
   wire reg_reset = (wr_acc & sel_rport & ~shared_reg) |
                    (wr_ctrl & pwdata[pbarb_pkg::CTRL_REGRST_BIT] & shared_reg); // see (RQ6)
   wire [2:0] err_in = {ring_overflow, fifo_overflow, fifo_underflow};
   wire reset_cause = hard_rst | stop_cmd | reg_reset | (|err_in); // see (RQ5)

   wire port_wr_acc = wr_acc & sel_port & rbusy_reg & ~rdir_read_reg;
   wire port_rd_acc = rd_acc & sel_port & rd_port_live; // see (RQ14)
   wire cmd_rread = wr_acc & sel_cmd & pwdata[pbarb_pkg::CMD_RREAD_BIT];
   wire cmd_rwrite = wr_acc & sel_cmd & pwdata[pbarb_pkg::CMD_RWRITE_BIT];
   wire cmd_abort = wr_acc & sel_cmd & pwdata[pbarb_pkg::CMD_ABORT_BIT];
   wire [2:0] err_clr = (wr_acc & sel_stat) ? pwdata[pbarb_pkg::STAT_ERR_LSB +: 3] : 3'h0;

   // Arbitration requests
   wire local_go = fifo_req & armed_reg; // see (RQ13)
   wire host_go = shared_reg & host_req_s; // see (RQ11)
   // Remote DMA wants one byte: fetch when latch empty, store when latch full
   wire rdma_want = ~shared_reg & rbusy_reg &
                    (rdir_read_reg ? ~latch_full_reg : latch_full_reg); // see (RQ10)
   wire [3:0] burst_len = ({2'h0, burst_sel_reg} + 4'h1) * pbarb_pkg::BURST_UNIT;
   wire last_byte = (bcnt_reg == (burst_len - 4'h1));

   wire in_local = (state_reg == pbarb_pkg::ST_LOCAL);
   wire in_remote = (state_reg == pbarb_pkg::ST_REMOTE);
   wire rem_rd_cyc = in_remote & rdir_read_reg;
   wire rem_wr_cyc = in_remote & ~rdir_read_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         pbarb_pkg::ST_RESET: begin
            if (start_cmd) begin
               state_next = pbarb_pkg::ST_IDLE; // see (RQ7)
            end
         end
         pbarb_pkg::ST_IDLE: begin
            if (local_go) begin
               state_next = pbarb_pkg::ST_LOCAL; // see (RQ9) see (RQ21) see (RQ15)
            end else if (host_go) begin
               state_next = pbarb_pkg::ST_HOST;
            end else if (rdma_want) begin
               state_next = pbarb_pkg::ST_REMOTE; // see (RQ16)
            end else begin
               state_next = pbarb_pkg::ST_IDLE; // see (RQ8)
            end
         end
         pbarb_pkg::ST_LOCAL: begin
            if (last_byte) begin
               // Release the bus; a gap lets the host contend before remote work
               state_next = (rdma_want | host_go) ? pbarb_pkg::ST_GAP :
                            pbarb_pkg::ST_IDLE; // see (RQ12) see (RQ18)
            end
         end
         pbarb_pkg::ST_GAP: begin
            state_next = pbarb_pkg::ST_IDLE; // see (RQ18)
         end
         pbarb_pkg::ST_REMOTE: begin
            // One byte only, then release or hand straight to local
            state_next = local_go ? pbarb_pkg::ST_LOCAL :
                         pbarb_pkg::ST_IDLE; // see (RQ19) see (RQ20) see (RQ17)
         end
         pbarb_pkg::ST_HOST: begin
            if (!host_req_s) begin
               state_next = pbarb_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = pbarb_pkg::ST_RESET;
         end
      endcase
      if (reset_cause) begin
         state_next = pbarb_pkg::ST_RESET; // see (RQ5)
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= pbarb_pkg::ST_RESET; // see (RQ3)
      end else begin
         state_reg <= state_next; // see (RQ2)
      end
   end

   // Memory bus: driven only while a DMA channel owns it
   assign mem_drive = in_local | in_remote; // see (RQ22) see (RQ21)
   assign mem_addr = in_local ? ldma_addr_reg : (in_remote ? rsar_reg : 16'h0000);
   assign mem_wdata = (in_local & fifo_to_mem) ? fifo_wdata :
                      (rem_wr_cyc ? latch_reg : 8'h00);
   assign mem_wr = (in_local & fifo_to_mem) | rem_wr_cyc;
   assign mem_rd = (in_local & ~fifo_to_mem) | rem_rd_cyc;
   assign fifo_take = in_local & fifo_to_mem;
   assign fifo_rdata = fifo_rdata_reg;
   assign fifo_push = fifo_push_reg;
   assign host_grant = (state_reg == pbarb_pkg::ST_HOST);
   assign rx_enable = (state_reg != pbarb_pkg::ST_RESET); // see (RQ4)
   assign tx_enable = (state_reg != pbarb_pkg::ST_RESET); // see (RQ4)

   // Local burst counter and threshold re-arm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt_reg <= 4'h0;
         armed_reg <= 1'b1;
         ldma_addr_reg <= pbarb_pkg::LDMA_ADDR_RST;
         fifo_rdata_reg <= 8'h00;
         fifo_push_reg <= 1'b0;
      end else begin
         fifo_push_reg <= in_local & ~fifo_to_mem;
         if (in_local & ~fifo_to_mem) begin
            fifo_rdata_reg <= mem_rdata;
         end
         if (in_local) begin
            bcnt_reg <= last_byte ? 4'h0 : bcnt_reg + 4'h1; // see (RQ12)
            ldma_addr_reg <= ldma_addr_reg + 16'h0001;
         end else if (wr_acc & sel_ldma) begin
            ldma_addr_reg <= pwdata[15:0];
         end
         if (in_local & last_byte) begin
            armed_reg <= 1'b0; // see (RQ13)
         end else if (!fifo_req) begin
            armed_reg <= 1'b1;
         end
      end
   end

   // Remote DMA channel and data latch; counters only move on a granted byte,
   // so a preempted transfer resumes at the same address and count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsar_reg <= pbarb_pkg::RSAR_RST;
         rbcr_reg <= pbarb_pkg::RBCR_RST;
         rbusy_reg <= 1'b0;
         rdir_read_reg <= 1'b1;
         latch_reg <= 8'h00;
         latch_full_reg <= 1'b0;
      end else if (reset_cause | cmd_abort) begin
         rbusy_reg <= 1'b0;
         latch_full_reg <= 1'b0;
      end else if (in_remote) begin
         rsar_reg <= rsar_reg + 16'h0001; // see (RQ16)
         rbcr_reg <= rbcr_reg - 16'h0001;
         rbusy_reg <= (rbcr_reg != 16'h0001);
         latch_full_reg <= rdir_read_reg;
         if (rdir_read_reg) begin
            latch_reg <= mem_rdata;
         end
      end else if (cmd_rread | cmd_rwrite) begin
         rbusy_reg <= (rbcr_reg != 16'h0000);
         rdir_read_reg <= cmd_rread;
         latch_full_reg <= 1'b0;
      end else begin
         if (wr_acc & sel_rsar) begin
            rsar_reg <= pwdata[15:0];
         end
         if (wr_acc & sel_rbcr) begin
            rbcr_reg <= pwdata[15:0];
         end
         if (port_wr_acc) begin
            latch_reg <= pwdata[7:0];
            latch_full_reg <= 1'b1;
         end else if (port_rd_acc) begin
            latch_full_reg <= 1'b0;
         end
      end
   end

   // Configuration and sticky error flags; a new error wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_reg <= pbarb_pkg::SHARED_RST;
         burst_sel_reg <= pbarb_pkg::DCFG_BURST_RST;
         err_reg <= 3'h0;
      end else begin
         if (wr_ctrl) begin
            shared_reg <= pwdata[pbarb_pkg::CTRL_SHARED_BIT];
         end
         if (wr_acc & sel_dcfg) begin
            burst_sel_reg <= pwdata[1:0];
         end
         err_reg <= (err_reg & ~err_clr) | err_in;
      end
   end

   // Read path is registered; a data port read completes only after the
   // fetched byte has already been captured into prdata
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      case (1'b1)
         sel_ctrl: rd_mux[pbarb_pkg::CTRL_SHARED_BIT] = shared_reg;
         sel_dcfg: rd_mux[1:0] = burst_sel_reg;
         sel_rsar: rd_mux[15:0] = rsar_reg;
         sel_rbcr: rd_mux[15:0] = rbcr_reg;
         sel_port: rd_mux[7:0] = latch_reg;
         sel_stat: begin
            rd_mux[pbarb_pkg::STAT_STATE_LSB +: 3] = state_reg;
            rd_mux[pbarb_pkg::STAT_RBUSY_BIT] = rbusy_reg;
            rd_mux[pbarb_pkg::STAT_LATCH_BIT] = latch_full_reg;
            rd_mux[pbarb_pkg::STAT_SHARED_BIT] = shared_reg;
            rd_mux[pbarb_pkg::STAT_ERR_LSB +: 3] = err_reg;
         end
         sel_ldma: rd_mux[15:0] = ldma_addr_reg;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
         rd_ok_reg <= 1'b0;
      end else begin
         if (psel & ~pwrite) begin
            prdata_reg <= rd_mux;
         end
         rd_ok_reg <= psel & latch_full_reg & ~port_rd_acc;
      end
   end

endmodule

`default_nettype wire

// ### verification/pbarb_arbiter_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module pbarb_arbiter_asserts (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic pready, // APB ready
   input wire logic hard_reset_pin_n, // Hard reset pin
   input wire logic host_grant, // Host owns bus
   input wire logic [7:0] fifo_wdata, // FIFO byte in
   input wire logic fifo_take, // FIFO byte used
   input wire logic [7:0] fifo_rdata, // FIFO byte out
   input wire logic fifo_push, // FIFO byte valid
   input wire logic fifo_underflow, // Error
   input wire logic fifo_overflow, // Error
   input wire logic ring_overflow, // Error
   input wire logic rx_enable, // Receiver on
   input wire logic tx_enable, // Transmitter on
   input wire logic mem_drive, // Bus enable
   input wire logic [15:0] mem_addr, // Address
   input wire logic [7:0] mem_wdata, // Write data
   input wire logic [7:0] mem_rdata, // Read data
   input wire logic mem_rd, // Read strobe
   input wire logic mem_wr // Write strobe
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_RXTX: assert property (!tx_enable && !(psel && penable && pwrite && pwdata[0]
      && paddr == pbarb_pkg::ADDR_CTRL) |=> !tx_enable && !rx_enable)
      else $error("reset state left without start command");
   AST_RESET_QUIET: assert property (!rx_enable |-> !mem_drive && !host_grant)
      else $error("bus owned while in reset state");
   AST_UNDRIVEN: assert property (!mem_drive |-> !mem_rd && !mem_wr && mem_addr == 16'h0000 && mem_wdata == 8'h00)
      else $error("memory outputs active while undriven");
   AST_ONE_OWNER: assert property (host_grant |-> !mem_drive && !fifo_take)
      else $error("host and arbiter both own the bus");
   AST_ONE_STROBE: assert property (mem_drive |-> mem_rd != mem_wr)
      else $error("driven cycle without exactly one strobe");
   AST_ERR: assert property ((fifo_underflow || fifo_overflow || ring_overflow) |=> !rx_enable)
      else $error("error did not force reset state");
   AST_START: assert property (psel && penable && pready && pwrite && paddr == pbarb_pkg::ADDR_CTRL
      && pwdata[2:0] == 3'h1 && hard_reset_pin_n && $past(hard_reset_pin_n, 6)
      && !(fifo_underflow || fifo_overflow || ring_overflow) |=> rx_enable)
      else $error("start command did not leave reset");
   AST_TAKE: assert property (fifo_take |-> mem_drive && mem_wr && mem_wdata == fifo_wdata)
      else $error("FIFO byte taken without matching write");
   AST_PUSH: assert property (fifo_push |-> $past(mem_rd) && fifo_rdata == $past(mem_rdata))
      else $error("FIFO push without preceding read");
   AST_ADDR_INC: assert property (fifo_take && $past(fifo_take) |-> mem_addr == $past(mem_addr) + 16'h0001)
      else $error("burst address did not step by one");
   AST_GAP: assert property (fifo_take |=> fifo_take || !mem_drive)
      else $error("remote cycle straight after local burst");
   AST_APB: assert property (psel && penable && paddr != pbarb_pkg::ADDR_DATA_PORT |-> pready)
      else $error("register access not answered at once");
endmodule

bind pbarb_arbiter pbarb_arbiter_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .hard_reset_pin_n, .host_grant, .fifo_wdata, .fifo_take, .fifo_rdata,
   .fifo_push, .fifo_underflow, .fifo_overflow, .ring_overflow, .rx_enable, .tx_enable,
   .mem_drive, .mem_addr, .mem_wdata, .mem_rdata, .mem_rd, .mem_wr);

`default_nettype wire

// ### verification/pbarb_ram_model.sv
`timescale 1ns/1ps
`default_nettype none

module pbarb_ram_model (
   input wire logic pclk, // Clock
   input wire logic mem_drive, // Bus driven
   input wire logic [15:0] mem_addr, // Address
   input wire logic [7:0] mem_wdata, // Write data
   input wire logic mem_rd, // Read strobe
   input wire logic mem_wr, // Write strobe
   output logic [7:0] mem_rdata // Read data
);
   logic [7:0] mem [0:255];
   logic [7:0] last_q = 8'h00;
   // Released bus shows the inverse of the last byte, so a late sample is caught
   assign mem_rdata = (mem_drive && mem_rd) ? mem[mem_addr[7:0]] : ~last_q;
   always @(posedge pclk) begin
      if (mem_drive && mem_wr) begin
         mem[mem_addr[7:0]] <= mem_wdata;
      end
      if (mem_drive && mem_rd) begin
         last_q <= mem[mem_addr[7:0]];
      end
   end
endmodule

`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
   logic [7:0] paddr, fifo_wdata, fifo_rdata, mem_wdata, mem_rdata;
   logic [31:0] pwdata, prdata, rd_q;
   logic hard_reset_pin_n, host_req_pin, host_grant, fifo_req, fifo_to_mem, fifo_take;
   logic fifo_push, fifo_underflow, fifo_overflow, ring_overflow, rx_enable, tx_enable;
   logic mem_drive, mem_rd, mem_wr;
   logic [15:0] mem_addr;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;

   pbarb_arbiter i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .hard_reset_pin_n, .host_req_pin, .host_grant, .fifo_req, .fifo_to_mem,
      .fifo_wdata, .fifo_take, .fifo_rdata, .fifo_push, .fifo_underflow, .fifo_overflow,
      .ring_overflow, .rx_enable, .tx_enable, .mem_drive, .mem_addr, .mem_wdata, .mem_rdata,
      .mem_rd, .mem_wr);
   pbarb_ram_model u_ram (.pclk, .mem_drive, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata);

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic report_and_stop();
      if (err_total == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         report_and_stop();
      end
   end

   // Fresh byte per take so every RAM location is distinct
   always @(posedge pclk) if (fifo_take === 1'b1) fifo_wdata <= fifo_wdata + 8'h01;

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) chk("pready", pready, 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic t_reset_state();
      @(negedge pclk);
      chk("tx_enable", tx_enable, 1'b0);
      apb(1'b0, pbarb_pkg::ADDR_STATUS, 32'h0);
      chk("state", rd_q[2:0], pbarb_pkg::ST_RESET);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", err_q, 1'b1);
      apb(1'b1, pbarb_pkg::ADDR_CTRL, 32'h1);
      @(negedge pclk);
      chk("rx_enable", rx_enable, 1'b1);
      repeat (10) begin
         @(negedge pclk);
         chk("idle_drive", mem_drive, 1'b0);
      end
   endtask

   task automatic t_local();
      int cnt;
      apb(1'b1, pbarb_pkg::ADDR_DATA_CONFIG, 32'h1);
      apb(1'b1, pbarb_pkg::ADDR_LDMA_ADDR, 32'h40);
      for (int b = 0; b < 3; b++) begin
         cnt = 0;
         if (b == 2) apb(1'b1, pbarb_pkg::ADDR_LDMA_ADDR, 32'h40);
         @(posedge pclk);
         fifo_to_mem <= (b < 2);
         fifo_req <= 1'b1;
         repeat (20) begin
            @(negedge pclk);
            if (fifo_take === 1'b1) cnt++;
            if (fifo_push === 1'b1) chk("fifo_rdata", fifo_rdata, 8'h10 + cnt);
            if (fifo_push === 1'b1) cnt++;
         end
         chk("burst_bytes", cnt, 4);
         @(posedge pclk);
         fifo_req <= 1'b0;
         fifo_to_mem <= 1'b1;
      end
      for (int i = 0; i < 8; i++) chk("ram", u_ram.mem[8'h40 + i], 8'h10 + i);
   endtask

   task automatic t_remote();
      apb(1'b1, pbarb_pkg::ADDR_RSAR, 32'h40);
      apb(1'b1, pbarb_pkg::ADDR_RBCR, 32'h3);
      apb(1'b1, pbarb_pkg::ADDR_RDMA_CMD, 32'h1);
      fifo_req <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         apb(1'b0, pbarb_pkg::ADDR_DATA_PORT, 32'h0);
         chk("port_read", rd_q[7:0], 8'h10 + k);
      end
      fifo_req <= 1'b0;
      apb(1'b0, pbarb_pkg::ADDR_STATUS, 32'h0);
      chk("rdma_busy", rd_q[3], 1'b0);
      apb(1'b1, pbarb_pkg::ADDR_RSAR, 32'h80);
      apb(1'b1, pbarb_pkg::ADDR_RBCR, 32'h2);
      apb(1'b1, pbarb_pkg::ADDR_RDMA_CMD, 32'h2);
      apb(1'b1, pbarb_pkg::ADDR_DATA_PORT, 32'h5A);
      apb(1'b1, pbarb_pkg::ADDR_DATA_PORT, 32'hC3);
      repeat (8) @(posedge pclk);
      chk("ram_wr0", u_ram.mem[8'h80], 8'h5A);
      chk("ram_wr1", u_ram.mem[8'h81], 8'hC3);
   endtask

   task automatic t_causes();
      for (int c = 0; c < 6; c++) begin
         apb(1'b1, pbarb_pkg::ADDR_CTRL, 32'h1);
         @(posedge pclk);
         fifo_underflow <= (c == 0);
         fifo_overflow <= (c == 1);
         ring_overflow <= (c == 2);
         hard_reset_pin_n <= (c != 5);
         @(posedge pclk);
         fifo_underflow <= 1'b0;
         fifo_overflow <= 1'b0;
         ring_overflow <= 1'b0;
         if (c == 3) apb(1'b1, pbarb_pkg::ADDR_CTRL, 32'h2);
         if (c == 4) apb(1'b1, pbarb_pkg::ADDR_RESET_PORT, 32'h1);
         if (c == 5) repeat (8) @(posedge pclk);
         if (c == 5) apb(1'b1, pbarb_pkg::ADDR_CTRL, 32'h1);
         @(negedge pclk);
         chk("rx_enable", rx_enable, 1'b0);
         apb(1'b0, pbarb_pkg::ADDR_STATUS, 32'h0);
         chk("err_bits", rd_q[10:8], (c < 3) ? 3'h1 << c : 3'h0);
         apb(1'b1, pbarb_pkg::ADDR_STATUS, 32'h700);
         hard_reset_pin_n <= 1'b1;
         repeat (8) @(posedge pclk);
      end
   endtask

   task automatic t_shared();
      int n;
      apb(1'b1, pbarb_pkg::ADDR_CTRL, 32'h9);
      host_req_pin <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (host_grant !== 1'b1 && n < 20);
      chk("host_grant", host_grant, 1'b1);
      chk("mem_drive", mem_drive, 1'b0);
      @(posedge pclk);
      host_req_pin <= 1'b0;
      apb(1'b1, pbarb_pkg::ADDR_RESET_PORT, 32'h1);
      @(negedge pclk);
      chk("rx_shared_port", rx_enable, 1'b1);
      apb(1'b1, pbarb_pkg::ADDR_CTRL, 32'hC);
      @(negedge pclk);
      chk("rx_shared_bit", rx_enable, 1'b0);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hard_reset_pin_n = 1'b1;
      host_req_pin = 1'b0;
      fifo_req = 1'b0;
      fifo_to_mem = 1'b1;
      fifo_wdata = 8'h10;
      fifo_underflow = 1'b0;
      fifo_overflow = 1'b0;
      ring_overflow = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_state();
      t_local();
      t_remote();
      t_causes();
      t_shared();
      report_and_stop();
   end
endmodule

`default_nettype wire
